/* File: dv/mii_phy_model.sv */
`timescale 1ns/1ns
module mii_phy_model (
    input  wire logic       tx_enable_i,
    input  wire logic [3:0] tx_nibble_i,
    output logic            tx_clock_o,
    output logic            rx_clock_o,
    output logic            carrier_o,
    output logic            collision_o,
    output logic            rx_valid_o,
    output logic            rx_error_o,
    output logic [3:0]      rx_nibble_o
);
    logic       tx_run = 1'b0;
    logic [3:0] seen_q[$];

    // Odd offset keeps link edges off the core clock edges
    initial begin
        {tx_clock_o, rx_clock_o, carrier_o, collision_o} = '0;
        {rx_valid_o, rx_error_o, rx_nibble_o} = '0;
        #137;
        forever begin
            #400;
            tx_clock_o = tx_run ? ~tx_clock_o : 1'b0;
        end
    end

    always @(posedge tx_clock_o) if (tx_enable_i) seen_q.push_back(tx_nibble_i);

    task automatic send_frame(input logic [15:0] d, input int err_at);
        for (int i = 0; i <= 4; i++) begin
            rx_valid_o = (i < 4);
            rx_error_o = (i == err_at);
            carrier_o = (i < 4);
            rx_nibble_o = (i < 4) ? d[4*i +: 4] : ~rx_nibble_o;
            #400 rx_clock_o = 1'b1;
            #400 rx_clock_o = 1'b0;
        end
        rx_nibble_o = ~rx_nibble_o;
    endtask
endmodule

/* File: dv/mii_port_sva.sv */
`timescale 1ns/1ns
module mii_port_sva (
    input wire logic                    core_clk_i,
    input wire logic                    nrst_i,
    input wire logic                    ethernet_select_strap_i,
    input wire logic                    pci_select_strap_i,
    input wire logic                    full_duplex_i,
    input wire logic                    collision_sense_in_i,
    input wire logic                    rx_valid_in_i,
    input wire mii_port_pkg::tx_word_t  tx_word_i,
    input wire logic                    tx_enable_out_o,
    input wire logic [3:0]              tx_nibble_out_o,
    input wire logic                    tx_pins_oe_n_o,
    input wire logic                    tx_taken_o,
    input wire logic                    tx_collision_o,
    input wire logic                    tx_busy_o,
    input wire logic                    rx_strobe_o,
    input wire mii_port_pkg::pin_func_t pin_func_o,
    input wire logic                    strap_done_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    property p_busy; tx_busy_o == tx_enable_out_o; endproperty
    a_busy: assert property (p_busy) else $error("busy differs from enable");
    property p_idle; !tx_enable_out_o |-> tx_nibble_out_o == 4'h0; endproperty
    a_idle: assert property (p_idle) else $error("nibble not idle");
    property p_taken;
        tx_taken_o |-> tx_enable_out_o && tx_nibble_out_o == $past(tx_word_i.nibble);
    endproperty
    a_taken: assert property (p_taken) else $error("taken nibble wrong");
    property p_hold; tx_enable_out_o && !tx_taken_o |-> $stable(tx_nibble_out_o); endproperty
    a_hold: assert property (p_hold) else $error("nibble moved between rises");
    property p_fd; (full_duplex_i && collision_sense_in_i) [*6] |-> !$rose(tx_enable_out_o);
    endproperty
    a_fd: assert property (p_fd) else $error("frame began under collision");
    property p_coll;
        tx_collision_o |-> !full_duplex_i && !tx_enable_out_o && $past(tx_enable_out_o);
    endproperty
    a_coll: assert property (p_coll) else $error("bad collision abort");
    property p_rxv; !rx_valid_in_i [*8] |=> !rx_strobe_o; endproperty
    a_rxv: assert property (p_rxv) else $error("nibble taken without valid");
    property p_func;
        strap_done_o |-> pin_func_o == (pci_select_strap_i ? mii_port_pkg::PIN_FN_PCI :
            ethernet_select_strap_i ? mii_port_pkg::PIN_FN_ETHERNET :
            mii_port_pkg::PIN_FN_HOST_PORT);
    endproperty
    a_func: assert property (p_func) else $error("pin function wrong");
    property p_host;
        pin_func_o != mii_port_pkg::PIN_FN_ETHERNET |-> tx_pins_oe_n_o && !tx_enable_out_o;
    endproperty
    a_host: assert property (p_host) else $error("pins driven outside Ethernet");
endmodule

bind mii_port mii_port_sva i_sva (.core_clk_i, .nrst_i, .ethernet_select_strap_i,
    .pci_select_strap_i, .full_duplex_i, .collision_sense_in_i, .rx_valid_in_i, .tx_word_i,
    .tx_enable_out_o, .tx_nibble_out_o, .tx_pins_oe_n_o, .tx_taken_o, .tx_collision_o,
    .tx_busy_o, .rx_strobe_o, .pin_func_o, .strap_done_o);

/* File: dv/tb.sv */
`timescale 1ns/1ns
module tb;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic ethernet_select_strap_i = 1'b1;
    logic pci_select_strap_i = 1'b0;
    logic full_duplex_i = 1'b0;
    logic tx_valid_i = 1'b0;
    mii_port_pkg::tx_word_t tx_word_i = '0;
    mii_port_pkg::rx_word_t rx_word_o;
    mii_port_pkg::pin_func_t pin_func_o;
    logic tx_clock_in_i, rx_clock_in_i, carrier_sense_in_i, collision_sense_in_i;
    logic rx_valid_in_i, rx_error_in_i, tx_enable_out_o, tx_pins_oe_n_o, tx_taken_o;
    logic tx_collision_o, tx_underrun_o, rx_strobe_o, rx_frame_end_o, rx_frame_err_o;
    logic strap_done_o;
    logic carrier_o;
    logic [3:0] rx_nibble_in_i, tx_nibble_out_o;
    logic [3:0] rxq[$];
    int fails = 0;
    int comparisons = 0;
    int n_coll = 0;
    int n_under = 0;
    int n_end = 0;
    int n_crs = 0;
    int n_nerr = 0;

    mii_port i_dut (.core_clk_i, .nrst_i, .ethernet_select_strap_i, .pci_select_strap_i,
        .full_duplex_i, .tx_clock_in_i, .rx_clock_in_i, .carrier_sense_in_i,
        .collision_sense_in_i, .rx_valid_in_i, .rx_error_in_i, .rx_nibble_in_i,
        .tx_enable_out_o, .tx_nibble_out_o, .tx_pins_oe_n_o, .tx_valid_i, .tx_word_i,
        .tx_taken_o, .tx_collision_o, .tx_underrun_o, .tx_busy_o(), .rx_strobe_o, .rx_word_o,
        .rx_frame_end_o, .rx_frame_err_o, .carrier_o, .pin_func_o, .strap_done_o);
    mii_phy_model i_phy (.tx_enable_i(tx_enable_out_o), .tx_nibble_i(tx_nibble_out_o),
        .tx_clock_o(tx_clock_in_i), .rx_clock_o(rx_clock_in_i), .carrier_o(carrier_sense_in_i),
        .collision_o(collision_sense_in_i), .rx_valid_o(rx_valid_in_i),
        .rx_error_o(rx_error_in_i), .rx_nibble_o(rx_nibble_in_i));

    always #50 core_clk_i = ~core_clk_i;

    always @(negedge core_clk_i) begin
        if (rx_strobe_o) rxq.push_back(rx_word_o.nibble);
        if (rx_strobe_o && carrier_o) n_crs++;
        if (rx_strobe_o && rx_word_o.error) n_nerr++;
        if (rx_frame_end_o) n_end++;
        if (tx_collision_o) n_coll++;
        if (tx_underrun_o) n_under++;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Straps only move inside reset, as on a real board
    task automatic restart(input logic eth, input logic pci);
        @(negedge core_clk_i);
        nrst_i = 1'b0;
        ethernet_select_strap_i = eth;
        pci_select_strap_i = pci;
        repeat (6) @(negedge core_clk_i);
        nrst_i = 1'b1;
        repeat (12) @(negedge core_clk_i);
    endtask

    task automatic tx_send(input logic [15:0] d, input int cnt, input logic fin);
        int i;
        int w;
        i = 0;
        w = 0;
        i_phy.seen_q.delete();
        i_phy.tx_run = 1'b1;
        tx_valid_i = 1'b1;
        tx_word_i = {fin && cnt == 1, d[3:0]};
        while (i < cnt && w < 400) begin
            @(negedge core_clk_i);
            w++;
            if (tx_taken_o) begin
                i++;
                tx_valid_i = (i < cnt);
                tx_word_i = {fin && i == cnt - 1, d[4*(i%4) +: 4]};
            end
        end
        tx_valid_i = 1'b0;
        repeat (40) @(negedge core_clk_i);
        i_phy.tx_run = 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_straps;
        mii_port_pkg::pin_func_t exp;
        for (int k = 0; k < 4; k++) begin
            restart(k[0], k[1]);
            exp = k[1] ? mii_port_pkg::PIN_FN_PCI :
                k[0] ? mii_port_pkg::PIN_FN_ETHERNET : mii_port_pkg::PIN_FN_HOST_PORT;
            check(pin_func_o, exp);
            check(strap_done_o, 1'b1);
            check(tx_pins_oe_n_o, exp != mii_port_pkg::PIN_FN_ETHERNET);
            rxq.delete();
            i_phy.send_frame(16'h5A3C, 9);
            repeat (10) @(negedge core_clk_i);
            check(rxq.size(), (k == 1) ? 4 : 0);
        end
        $display("test straps done");
    endtask

    task automatic t_tx;
        restart(1'b1, 1'b0);
        tx_send(16'hA5C3, 4, 1'b1);
        check(i_phy.seen_q.size(), 4);
        check({i_phy.seen_q[3], i_phy.seen_q[2], i_phy.seen_q[1], i_phy.seen_q[0]}, 16'hA5C3);
        check(tx_enable_out_o, 1'b0);
        tx_send(16'h0021, 2, 1'b0);
        check(i_phy.seen_q.size(), 2);
        check(n_under, 1);
        fork
            tx_send(16'h4321, 4, 1'b1);
            begin
                repeat (20) @(negedge core_clk_i);
                i_phy.collision_o = 1'b1;
                // Longer than one link period so a sampled rise is hit
                repeat (10) @(negedge core_clk_i);
                i_phy.collision_o = 1'b0;
            end
        join
        check(n_coll, 1);
        full_duplex_i = 1'b1;
        i_phy.collision_o = 1'b1;
        fork
            tx_send(16'h0009, 1, 1'b1);
            begin
                repeat (60) @(negedge core_clk_i);
                check(tx_enable_out_o, 1'b0);
                i_phy.collision_o = 1'b0;
            end
        join
        check({i_phy.seen_q.size(), i_phy.seen_q[0]}, 16'h0019);
        full_duplex_i = 1'b0;
        $display("test transmit done");
    endtask

    task automatic t_rx;
        rxq.delete();
        n_end = 0;
        n_crs = 0;
        n_nerr = 0;
        i_phy.send_frame(16'h9E61, 9);
        repeat (10) @(negedge core_clk_i);
        check({rxq[3], rxq[2], rxq[1], rxq[0]}, 16'h9E61);
        check(rxq.size(), 4);
        check(rx_frame_err_o, 1'b0);
        check(n_end, 1);
        check(n_crs, 4);
        check(carrier_o, 1'b0);
        i_phy.send_frame(16'h1234, 2);
        repeat (10) @(negedge core_clk_i);
        check(rx_frame_err_o, 1'b1);
        check(n_nerr, 1);
        check(n_end, 2);
        $display("test receive done");
    endtask

    initial begin
        t_straps();
        t_tx();
        t_rx();
        stop_test();
    end

    initial begin
        #2000000;
        fails++;
        stop_test();
    end
endmodule

/* File: rtl/mii_port.sv */
`timescale 1ns/1ns
module mii_port (
    input  wire logic                   core_clk_i,
    input  wire logic                   nrst_i,
    // Boot straps and live duplex mode
    input  wire logic                   ethernet_select_strap_i,
    input  wire logic                   pci_select_strap_i,
    input  wire logic                   full_duplex_i,
    // PHY side
    input  wire logic                   tx_clock_in_i,
    input  wire logic                   rx_clock_in_i,
    input  wire logic                   carrier_sense_in_i,
    input  wire logic                   collision_sense_in_i,
    input  wire logic                   rx_valid_in_i,
    input  wire logic                   rx_error_in_i,
    input  wire logic [3:0]             rx_nibble_in_i,
    output logic                        tx_enable_out_o,
    output logic      [3:0]             tx_nibble_out_o,
    output logic                        tx_pins_oe_n_o,
    // Transmit user side
    input  wire logic                   tx_valid_i,
    input  wire mii_port_pkg::tx_word_t tx_word_i,
    output logic                        tx_taken_o,
    output logic                        tx_collision_o,
    output logic                        tx_underrun_o,
    output logic                        tx_busy_o,
    // Receive user side
    output logic                        rx_strobe_o,
    output mii_port_pkg::rx_word_t      rx_word_o,
    output logic                        rx_frame_end_o,
    output logic                        rx_frame_err_o,
    output logic                        carrier_o,
    // Pin function
    output mii_port_pkg::pin_func_t     pin_func_o,
    output logic                        strap_done_o
);

    // ----------------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------------
    localparam int unsigned SYNC_W = 12;

    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_lvl;

    assign pins_raw = {pci_select_strap_i, ethernet_select_strap_i,
                       collision_sense_in_i, carrier_sense_in_i,
                       rx_error_in_i, rx_valid_in_i, rx_nibble_in_i,
                       rx_clock_in_i, tx_clock_in_i};

    pin_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .pin_i      (pins_raw),
        .level_o    (pins_lvl)
    );

    logic       tx_clk_s;
    logic       rx_clk_s;
    logic [3:0] rx_nib_s;
    logic       rx_dv_s;
    logic       rx_er_s;
    logic       crs_s;
    logic       col_s;
    logic       strap_eth_s;
    logic       strap_pci_s;

    assign tx_clk_s    = pins_lvl[0];
    assign rx_clk_s    = pins_lvl[1];
    assign rx_nib_s    = pins_lvl[5:2];
    assign rx_dv_s     = pins_lvl[6];
    assign rx_er_s     = pins_lvl[7];
    assign crs_s       = pins_lvl[8];
    assign col_s       = pins_lvl[9];
    assign strap_eth_s = pins_lvl[10];
    assign strap_pci_s = pins_lvl[11];

    // ----------------------------------------------------------------
    // Link clock edges, found on the core clock
    // ----------------------------------------------------------------
    logic tx_clk_prev_q;
    logic rx_clk_prev_q;
    logic tx_rise;
    logic rx_rise;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_clk_prev_q <= 1'b0;
            rx_clk_prev_q <= 1'b0;
        end else begin
            tx_clk_prev_q <= tx_clk_s;
            rx_clk_prev_q <= rx_clk_s;
        end
    end

    // Clock from the PHY only; never generated here
    assign tx_rise = tx_clk_s & ~tx_clk_prev_q;
    assign rx_rise = rx_clk_s & ~rx_clk_prev_q;

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    // Straps sampled only once the synchroniser has filled after release
    logic [2:0]              settle_q;
    logic                    strap_done_q;
    mii_port_pkg::pin_func_t func_q;
    logic                    eth_sel;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            settle_q     <= 3'h0;
            strap_done_q <= 1'b0;
            func_q       <= mii_port_pkg::PIN_FN_HOST_PORT;
        end else if (!strap_done_q) begin
            // Synced strap level first stands after the fourth edge
            if (settle_q == 3'(mii_port_pkg::STRAP_SETTLE_CYCLES)) begin
                strap_done_q <= 1'b1;
                if (strap_pci_s) begin
                    func_q <= mii_port_pkg::PIN_FN_PCI;
                end else if (strap_eth_s) begin
                    func_q <= mii_port_pkg::PIN_FN_ETHERNET;
                end else begin
                    func_q <= mii_port_pkg::PIN_FN_HOST_PORT;
                end
            end
            settle_q <= settle_q + 3'h1;
        end
    end

    assign eth_sel = (func_q == mii_port_pkg::PIN_FN_ETHERNET);

    // ----------------------------------------------------------------
    // Transmit path
    // ----------------------------------------------------------------
    typedef enum logic {
        TX_IDLE,
        TX_SEND
    } tx_state_t;

    tx_state_t  tx_state_q;
    logic       tx_last_q;
    logic       tx_en_q;
    logic [3:0] tx_nib_q;
    logic       tx_taken_q;
    logic       tx_col_q;
    logic       tx_unr_q;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_state_q <= TX_IDLE;
            tx_last_q  <= 1'b0;
            tx_en_q    <= 1'b0;
            tx_nib_q   <= mii_port_pkg::NIBBLE_IDLE;
            tx_taken_q <= 1'b0;
            tx_col_q   <= 1'b0;
            tx_unr_q   <= 1'b0;
        end else begin
            tx_taken_q <= 1'b0;
            tx_col_q   <= 1'b0;
            tx_unr_q   <= 1'b0;
            if (!eth_sel) begin
                tx_state_q <= TX_IDLE;
                tx_en_q    <= 1'b0;
                tx_nib_q   <= mii_port_pkg::NIBBLE_IDLE;
            end else if (tx_rise) begin
                case (tx_state_q)
                    TX_IDLE: begin
                        // Collision holds off a new frame in full duplex
                        if (tx_valid_i && !(full_duplex_i && col_s)) begin
                            tx_state_q <= TX_SEND;
                            tx_en_q    <= 1'b1;
                            tx_nib_q   <= tx_word_i.nibble;
                            tx_last_q  <= tx_word_i.last;
                            tx_taken_q <= 1'b1;
                        end
                    end
                    TX_SEND: begin
                        if (!full_duplex_i && col_s) begin
                            tx_state_q <= TX_IDLE;
                            tx_en_q    <= 1'b0;
                            tx_nib_q   <= mii_port_pkg::NIBBLE_IDLE;
                            tx_col_q   <= 1'b1;
                        end else if (tx_last_q || !tx_valid_i) begin
                            // Data not ready in time ends the frame early
                            tx_state_q <= TX_IDLE;
                            tx_en_q    <= 1'b0;
                            tx_nib_q   <= mii_port_pkg::NIBBLE_IDLE;
                            tx_unr_q   <= ~tx_last_q;
                        end else begin
                            tx_nib_q   <= tx_word_i.nibble;
                            tx_last_q  <= tx_word_i.last;
                            tx_taken_q <= 1'b1;
                        end
                    end
                    default: begin
                        tx_state_q <= TX_IDLE;
                        tx_en_q    <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Receive path
    // ----------------------------------------------------------------
    logic       rx_in_frame_q;
    logic       rx_err_acc_q;
    logic       rx_stb_q;
    logic [3:0] rx_nib_q;
    logic       rx_nib_err_q;
    logic       rx_end_q;
    logic       rx_ferr_q;
    logic       crs_q;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_in_frame_q <= 1'b0;
            rx_err_acc_q  <= 1'b0;
            rx_stb_q      <= 1'b0;
            rx_nib_q      <= mii_port_pkg::NIBBLE_IDLE;
            rx_nib_err_q  <= 1'b0;
            rx_end_q      <= 1'b0;
            rx_ferr_q     <= 1'b0;
            crs_q         <= 1'b0;
        end else begin
            rx_stb_q <= 1'b0;
            rx_end_q <= 1'b0;
            crs_q    <= eth_sel & crs_s;
            if (rx_rise && eth_sel && rx_dv_s) begin
                rx_nib_q      <= rx_nib_s;
                rx_nib_err_q  <= rx_er_s;
                rx_stb_q      <= 1'b1;
                rx_in_frame_q <= 1'b1;
                rx_err_acc_q  <= rx_err_acc_q | rx_er_s;
            end else if (rx_in_frame_q && (rx_rise || !eth_sel)) begin
                rx_end_q      <= 1'b1;
                rx_ferr_q     <= rx_err_acc_q;
                rx_in_frame_q <= 1'b0;
                rx_err_acc_q  <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    logic oe_n_q;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= ~eth_sel;
        end
    end

    assign tx_enable_out_o  = tx_en_q;
    assign tx_nibble_out_o  = tx_nib_q;
    assign tx_pins_oe_n_o   = oe_n_q;
    assign tx_taken_o       = tx_taken_q;
    assign tx_collision_o   = tx_col_q;
    assign tx_underrun_o    = tx_unr_q;
    assign tx_busy_o        = tx_en_q;
    assign rx_strobe_o      = rx_stb_q;
    assign rx_word_o.nibble = rx_nib_q;
    assign rx_word_o.error  = rx_nib_err_q;
    assign rx_frame_end_o   = rx_end_q;
    assign rx_frame_err_o   = rx_ferr_q;
    assign carrier_o        = crs_q;
    assign pin_func_o       = func_q;
    assign strap_done_o     = strap_done_q;

endmodule

/* File: rtl/mii_port_pkg.sv */
package mii_port_pkg;

    // ----------------------------------------------------------------
    // Widths and timing
    // ----------------------------------------------------------------
    localparam int unsigned NIBBLE_W            = 4;
    localparam int unsigned STRAP_SETTLE_CYCLES = 4;
    localparam logic [3:0]  NIBBLE_IDLE         = 4'h0;

    // ----------------------------------------------------------------
    // Shared pin functions
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PIN_FN_HOST_PORT,
        PIN_FN_ETHERNET,
        PIN_FN_PCI
    } pin_func_t;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                last;
        logic [NIBBLE_W-1:0] nibble;
    } tx_word_t;

    typedef struct packed {
        logic                error;
        logic [NIBBLE_W-1:0] nibble;
    } rx_word_t;

endpackage

/* File: rtl/pin_sync.sv */
`timescale 1ns/1ns
module pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             core_clk_i,
    input  wire logic             nrst_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] level_o
);
    // ----------------------------------------------------------------
    // Three stages; a new level counts once stages two and three agree
    // ----------------------------------------------------------------
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        logic s1_q;
        logic s2_q;
        logic s3_q;
        logic lvl_q;

        always_ff @(posedge core_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                s1_q  <= 1'b0;
                s2_q  <= 1'b0;
                s3_q  <= 1'b0;
                lvl_q <= 1'b0;
            end else begin
                s1_q <= pin_i[b];
                s2_q <= s1_q;
                s3_q <= s2_q;
                if (s2_q == s3_q) begin
                    lvl_q <= s3_q;
                end
            end
        end

        assign level_o[b] = lvl_q;
    end

endmodule
